// >>> core/pmcr_pkg.sv
// constants for the proximity measurement configuration register bank
// assumes a byte-wide register port addressed by the printed 8-bit offsets
package pmcr_pkg;
  // register offsets
  localparam logic [7:0] OFF_DUTY_WIDTH = 8'h82;
  localparam logic [7:0] OFF_DRIVE_LEVEL = 8'h83;
  localparam logic [7:0] OFF_PULSE_COUNT = 8'h84;
  localparam logic [7:0] OFF_GAIN = 8'h93;
  localparam logic [7:0] OFF_TIMING = 8'h94;
  localparam logic [7:0] OFF_DUTY_WIDTH_CMP = 8'h95;
  localparam logic [7:0] OFF_DRIVE_LEVEL_CMP = 8'h96;
  localparam logic [7:0] OFF_PULSE_COUNT_CMP = 8'h97;
  localparam logic [7:0] OFF_STATUS = 8'h99;
  localparam logic [7:0] OFF_CONTROL = 8'h81;
  // reset values
  localparam logic [7:0] RST_DUTY_WIDTH = 8'h0e;
  localparam logic [7:0] RST_DRIVE_LEVEL = 8'h0f;
  localparam logic [7:0] RST_PULSE_COUNT = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h10;
  localparam logic [7:0] RST_TIMING = 8'ha9;
  localparam logic [7:0] RST_DUTY_WIDTH_CMP = 8'h01;
  localparam logic [7:0] RST_DRIVE_LEVEL_CMP = 8'h10;
  localparam logic [7:0] RST_PULSE_COUNT_CMP = 8'hff;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // significant bit masks of each primary and its complement
  localparam logic [7:0] MASK_DUTY_WIDTH = 8'h0f;
  localparam logic [7:0] MASK_DRIVE_LEVEL = 8'h1f;
  localparam logic [7:0] MASK_PULSE_COUNT = 8'hff;
  // field positions
  localparam int GAIN_LSB = 0;
  localparam int AVG_LSB = 4;
  localparam int ACCUM_BIT = 6;
  localparam int CTRL_SW_RESET_BIT = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int STAT_DATA_BIT = 0;
  localparam int STAT_INVALID_BIT = 3;
  // timing: one tick of 3.125 ms, intervals expressed in ticks
  localparam int CLK_HZ = 40000000;
  localparam int TICK_NS = 3125000;
  localparam int TICK_CYCLES = TICK_NS / (1000000000 / CLK_HZ);
  // sequencer states
  typedef enum logic [1:0] {
    PMCR_IDLE = 2'b00,
    PMCR_WAIT = 2'b01,
    PMCR_DONE = 2'b10
  } pmcr_state_t;
endpackage : pmcr_pkg

// >>> core/pmcr_regs.sv
// register bank and measurement pacing for the proximity sensor
// assumes synchronous single-cycle strobes; read data stands one cycle after
`timescale 1ns/100ps
// Behaviour
// (R1) pulse count field gives programmed value plus one pulses per measurement
// (R2) software writes pulse count and its complement together, inverted
// (R3) gain resets 0x10, low two bits select 1x/2x/4x/8x
// (R4) active mode repeats measurements once per programmed interval
// (R5) timing resets 0xa9, codes 0011..1101 map to 3.125..200 ms
// (R6) bits 5:4 choose one, two, four or eight combined samples
// (R7) bit 6 selects average when clear, accumulated sum when set
// (R8) duty/width complement resets 0x01, reserved upper nibble reads zero
// (R9) software updates duty/width complement with its primary
// (R10) drive level complement resets 0x10, written with its primary
// (R11) invalid flag raised when any complement mismatches its primary
// (R12) all registers return to defaults on reset and software reset, except the status new-data bit, which software reset keeps
module pmcr_regs #(
  parameter int TICK_CYC = pmcr_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic [8:0] PULSE_BURST,
  output logic [1:0] GAIN_SEL,
  output logic [3:0] SAMPLE_SHIFT,
  output logic ACCUMULATE,
  output logic LED_INVALID,
  output logic MEAS_START
);
  logic rst_meta, rst_n;
  logic [7:0] duty_width_reg, drive_level_reg, led_pulse_count_reg;
  logic [7:0] sensing_gain_reg, measurement_timing_reg;
  logic [7:0] duty_width_complement_reg, drive_level_complement_reg;
  logic [7:0] pulse_count_complement_reg, control_reg;
  logic data_new_reg;
  logic sw_reset;
  logic invalid_next;
  logic [23:0] tick_cnt_reg;
  logic [7:0] interval_cnt_reg;
  logic [7:0] interval_ticks;
  logic tick;
  pmcr_pkg::pmcr_state_t state_reg;

  // reset release through two flops so every register leaves reset together
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // software reset is a write of one to the self-clearing control bit
  assign sw_reset = WR && ADDR == pmcr_pkg::OFF_CONTROL && WDATA[pmcr_pkg::CTRL_SW_RESET_BIT];

  // (R12) defaults on reset
  // (R3) gain default
  // (R5) timing default
  // (R8) duty/width complement default
  // (R10) drive complement default
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      duty_width_reg <= pmcr_pkg::RST_DUTY_WIDTH;
      drive_level_reg <= pmcr_pkg::RST_DRIVE_LEVEL;
      led_pulse_count_reg <= pmcr_pkg::RST_PULSE_COUNT;
      sensing_gain_reg <= pmcr_pkg::RST_GAIN;
      measurement_timing_reg <= pmcr_pkg::RST_TIMING;
      duty_width_complement_reg <= pmcr_pkg::RST_DUTY_WIDTH_CMP;
      drive_level_complement_reg <= pmcr_pkg::RST_DRIVE_LEVEL_CMP;
      pulse_count_complement_reg <= pmcr_pkg::RST_PULSE_COUNT_CMP;
      control_reg <= pmcr_pkg::RST_CONTROL;
    end else if (sw_reset) begin
      duty_width_reg <= pmcr_pkg::RST_DUTY_WIDTH;
      drive_level_reg <= pmcr_pkg::RST_DRIVE_LEVEL;
      led_pulse_count_reg <= pmcr_pkg::RST_PULSE_COUNT;
      sensing_gain_reg <= pmcr_pkg::RST_GAIN;
      measurement_timing_reg <= pmcr_pkg::RST_TIMING;
      duty_width_complement_reg <= pmcr_pkg::RST_DUTY_WIDTH_CMP;
      drive_level_complement_reg <= pmcr_pkg::RST_DRIVE_LEVEL_CMP;
      pulse_count_complement_reg <= pmcr_pkg::RST_PULSE_COUNT_CMP;
      control_reg <= pmcr_pkg::RST_CONTROL;
    end else if (WR) begin
      // reserved bits are not stored, so they read back as zero
      case (ADDR)
        pmcr_pkg::OFF_DUTY_WIDTH: duty_width_reg <= WDATA & pmcr_pkg::MASK_DUTY_WIDTH;
        pmcr_pkg::OFF_DRIVE_LEVEL: drive_level_reg <= WDATA & pmcr_pkg::MASK_DRIVE_LEVEL;
        pmcr_pkg::OFF_PULSE_COUNT: led_pulse_count_reg <= WDATA;
        pmcr_pkg::OFF_GAIN: sensing_gain_reg <= WDATA;
        pmcr_pkg::OFF_TIMING: measurement_timing_reg <= WDATA;
        pmcr_pkg::OFF_DUTY_WIDTH_CMP: begin
          duty_width_complement_reg <= WDATA & pmcr_pkg::MASK_DUTY_WIDTH;
        end
        pmcr_pkg::OFF_DRIVE_LEVEL_CMP: begin
          drive_level_complement_reg <= WDATA & pmcr_pkg::MASK_DRIVE_LEVEL;
        end
        pmcr_pkg::OFF_PULSE_COUNT_CMP: pulse_count_complement_reg <= WDATA;
        pmcr_pkg::OFF_CONTROL: control_reg <= {6'h00, WDATA[pmcr_pkg::CTRL_ACTIVE_BIT], 1'b0};
        default: ;
      endcase
    end
  end

  // (R11) complement mismatch check over significant bits only
  always_comb begin
    invalid_next = 1'b0;
    if ((duty_width_complement_reg ^ duty_width_reg) != pmcr_pkg::MASK_DUTY_WIDTH) begin
      invalid_next = 1'b1;
    end
    if ((drive_level_complement_reg ^ drive_level_reg) != pmcr_pkg::MASK_DRIVE_LEVEL) begin
      invalid_next = 1'b1;
    end
    if ((pulse_count_complement_reg ^ led_pulse_count_reg) != pmcr_pkg::MASK_PULSE_COUNT) begin
      invalid_next = 1'b1;
    end
  end

  // configuration outputs registered from the bank
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PULSE_BURST <= 9'h001;
      GAIN_SEL <= 2'h0;
      SAMPLE_SHIFT <= 4'h4;
      ACCUMULATE <= 1'b0;
      LED_INVALID <= 1'b0;
    end else begin
      // (R1) burst is count plus one
      PULSE_BURST <= {1'b0, led_pulse_count_reg} + 9'h001;
      // (R3) gain select
      GAIN_SEL <= sensing_gain_reg[pmcr_pkg::GAIN_LSB +: 2];
      // (R6) one-hot sample count
      SAMPLE_SHIFT <= 4'h1 << measurement_timing_reg[pmcr_pkg::AVG_LSB +: 2];
      // (R7) average or sum
      ACCUMULATE <= measurement_timing_reg[pmcr_pkg::ACCUM_BIT];
      // (R11) flag follows mismatch
      LED_INVALID <= invalid_next;
    end
  end

  // (R5) interval code to ticks of 3.125 ms; undefined codes use 100 ms
  always_comb begin
    case (measurement_timing_reg[3:0])
      4'h3: interval_ticks = 8'h01;
      4'h4: interval_ticks = 8'h02;
      4'h5: interval_ticks = 8'h04;
      4'h6: interval_ticks = 8'h08;
      4'h7: interval_ticks = 8'h10;
      4'h8: interval_ticks = 8'h18;
      4'h9: interval_ticks = 8'h20;
      4'ha: interval_ticks = 8'h28;
      4'hb: interval_ticks = 8'h30;
      4'hc: interval_ticks = 8'h38;
      4'hd: interval_ticks = 8'h40;
      default: interval_ticks = 8'h20;
    endcase
  end

  // tick divider, runs only in active mode
  assign tick = tick_cnt_reg == 24'(TICK_CYC - 1);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 24'h000000;
    end else if (!control_reg[pmcr_pkg::CTRL_ACTIVE_BIT] || tick) begin
      tick_cnt_reg <= 24'h000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
    end
  end

  // (R4) periodic measurement sequencer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pmcr_pkg::PMCR_IDLE;
      interval_cnt_reg <= 8'h00;
      MEAS_START <= 1'b0;
    end else begin
      MEAS_START <= 1'b0;
      case (state_reg)
        pmcr_pkg::PMCR_IDLE: begin
          interval_cnt_reg <= 8'h00;
          if (control_reg[pmcr_pkg::CTRL_ACTIVE_BIT]) begin
            state_reg <= pmcr_pkg::PMCR_WAIT;
          end
        end
        pmcr_pkg::PMCR_WAIT: begin
          if (!control_reg[pmcr_pkg::CTRL_ACTIVE_BIT]) begin
            state_reg <= pmcr_pkg::PMCR_IDLE;
          end else if (tick) begin
            if (interval_cnt_reg + 8'h01 >= interval_ticks) begin
              interval_cnt_reg <= 8'h00;
              state_reg <= pmcr_pkg::PMCR_DONE;
            end else begin
              interval_cnt_reg <= interval_cnt_reg + 8'h01;
            end
          end
        end
        pmcr_pkg::PMCR_DONE: begin
          MEAS_START <= 1'b1;
          state_reg <= pmcr_pkg::PMCR_WAIT;
        end
        default: state_reg <= pmcr_pkg::PMCR_IDLE;
      endcase
    end
  end

  // new-data bit: set by a measurement, cleared by a status read; set wins
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      data_new_reg <= 1'b0;
    end else if (state_reg == pmcr_pkg::PMCR_DONE) begin
      data_new_reg <= 1'b1;
    end else if (RD && ADDR == pmcr_pkg::OFF_STATUS) begin
      data_new_reg <= 1'b0;
    end
  end

  // read mux, data stands the cycle after the strobe only
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        pmcr_pkg::OFF_DUTY_WIDTH: RDATA <= duty_width_reg;
        pmcr_pkg::OFF_DRIVE_LEVEL: RDATA <= drive_level_reg;
        pmcr_pkg::OFF_PULSE_COUNT: RDATA <= led_pulse_count_reg;
        pmcr_pkg::OFF_GAIN: RDATA <= sensing_gain_reg;
        pmcr_pkg::OFF_TIMING: RDATA <= measurement_timing_reg;
        pmcr_pkg::OFF_DUTY_WIDTH_CMP: RDATA <= duty_width_complement_reg;
        pmcr_pkg::OFF_DRIVE_LEVEL_CMP: RDATA <= drive_level_complement_reg;
        pmcr_pkg::OFF_PULSE_COUNT_CMP: RDATA <= pulse_count_complement_reg;
        pmcr_pkg::OFF_CONTROL: RDATA <= control_reg;
        pmcr_pkg::OFF_STATUS: RDATA <= {4'h0, invalid_next, 2'h0, data_new_reg};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // (R11) flag tracks mismatch one cycle later
  a_invalid_flag: assert property (@(posedge CLK) disable iff (!rst_n)
    ##1 LED_INVALID == $past(invalid_next)) else $error("invalid flag wrong"); // (R11)

  // (R1) burst equals count plus one
  a_burst_count: assert property (@(posedge CLK) disable iff (!rst_n)
    ##1 PULSE_BURST == {1'b0, $past(led_pulse_count_reg)} + 9'h001)
    else $error("burst count wrong"); // (R1)

  // (R12) software reset restores the timing default
  a_soft_reset: assert property (@(posedge CLK) disable iff (!rst_n)
    sw_reset |=> measurement_timing_reg == pmcr_pkg::RST_TIMING &&
    sensing_gain_reg == pmcr_pkg::RST_GAIN) else $error("soft reset failed"); // (R12)

  // (R4) no measurement while standing by
  a_idle_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
    !control_reg[pmcr_pkg::CTRL_ACTIVE_BIT] ##1 !control_reg[pmcr_pkg::CTRL_ACTIVE_BIT]
    |=> !MEAS_START) else $error("start in standby"); // (R4)

  // (R4) starts are single pulses
  a_start_pulse: assert property (@(posedge CLK) disable iff (!rst_n)
    MEAS_START |=> !MEAS_START) else $error("start too long"); // (R4)

  // (R6) sample count is one-hot from field
  a_sample_count: assert property (@(posedge CLK) disable iff (!rst_n)
    ##1 $onehot(SAMPLE_SHIFT)) else $error("sample count not one-hot"); // (R6)

  // (R7) accumulate follows bit 6
  a_accum_mode: assert property (@(posedge CLK) disable iff (!rst_n)
    ##1 ACCUMULATE == $past(measurement_timing_reg[pmcr_pkg::ACCUM_BIT]))
    else $error("accumulate mode wrong"); // (R7)

  // (R8) reserved complement bits stay zero
  a_reserved_zero: assert property (@(posedge CLK) disable iff (!rst_n)
    duty_width_complement_reg[7:4] == 4'h0) else $error("reserved bits set"); // (R8)

  // (R3) gain output follows low bits
  a_gain_sel: assert property (@(posedge CLK) disable iff (!rst_n)
    ##1 GAIN_SEL == $past(sensing_gain_reg[1:0])) else $error("gain select wrong"); // (R3)

  // idle bus returns zero, so a stale byte is never taken for an answer
  a_read_idle: assert property (@(posedge CLK) disable iff (!rst_n)
    !RD |=> RDATA == 8'h00) else $error("read data not cleared");

  // (R11) status read shows the live mismatch flag
  a_status_invalid: assert property (@(posedge CLK) disable iff (!rst_n) // (R11)
    RD && ADDR == pmcr_pkg::OFF_STATUS |=>
    RDATA[pmcr_pkg::STAT_INVALID_BIT] == $past(invalid_next))
    else $error("status invalid bit wrong");

  // (R4) every measurement marks new data
  a_data_new_set: assert property (@(posedge CLK) disable iff (!rst_n) // (R4)
    state_reg == pmcr_pkg::PMCR_DONE |=> data_new_reg)
    else $error("new data not flagged");

  // (R4) status read clears new data unless a measurement lands with it
  a_status_clear: assert property (@(posedge CLK) disable iff (!rst_n) // (R4)
    RD && ADDR == pmcr_pkg::OFF_STATUS && state_reg != pmcr_pkg::PMCR_DONE |=> !data_new_reg)
    else $error("new data not cleared");

  // (R10) reserved drive complement bits stay zero
  a_drive_reserved: assert property (@(posedge CLK) disable iff (!rst_n) // (R10)
    drive_level_complement_reg[7:5] == 3'h0) else $error("drive reserved bits set");

  // (R9) primary duty/width keeps only the fields the complement mirrors
  a_duty_reserved: assert property (@(posedge CLK) disable iff (!rst_n) // (R9)
    duty_width_reg[7:4] == 4'h0) else $error("duty reserved bits set");

  // (R12) software reset restores the pulse count pair and complements
  a_soft_reset_bank: assert property (@(posedge CLK) disable iff (!rst_n) // (R12)
    sw_reset |=> led_pulse_count_reg == pmcr_pkg::RST_PULSE_COUNT &&
    pulse_count_complement_reg == pmcr_pkg::RST_PULSE_COUNT_CMP &&
    duty_width_complement_reg == pmcr_pkg::RST_DUTY_WIDTH_CMP &&
    drive_level_complement_reg == pmcr_pkg::RST_DRIVE_LEVEL_CMP)
    else $error("soft reset bank failed");

  // (R6) sample count follows the combining field exactly
  a_sample_shift: assert property (@(posedge CLK) disable iff (!rst_n) // (R6)
    ##1 SAMPLE_SHIFT == 4'h1 << $past(measurement_timing_reg[pmcr_pkg::AVG_LSB +: 2]))
    else $error("sample count does not follow field");

  // (R1) burst stays within one to 256 pulses
  a_burst_range: assert property (@(posedge CLK) disable iff (!rst_n) // (R1)
    PULSE_BURST != 9'h000 && PULSE_BURST <= 9'h100) else $error("burst out of range");

  // (R4) standby parks the sequencer so a later start begins a full interval
  a_standby_idle: assert property (@(posedge CLK) disable iff (!rst_n) // (R4)
    !control_reg[pmcr_pkg::CTRL_ACTIVE_BIT] ##1 !control_reg[pmcr_pkg::CTRL_ACTIVE_BIT]
    |=> state_reg == pmcr_pkg::PMCR_IDLE) else $error("sequencer not parked");

  // (R4) tick divider never runs past its terminal count
  a_tick_range: assert property (@(posedge CLK) disable iff (!rst_n) // (R4)
    tick_cnt_reg < 24'(TICK_CYC)) else $error("tick divider overrun");

  // (R4) a start needs active mode two edges earlier, when the interval ended
  a_start_active: assert property (@(posedge CLK) disable iff (!rst_n) // (R4)
    MEAS_START |-> $past(control_reg[pmcr_pkg::CTRL_ACTIVE_BIT], 2))
    else $error("start without active mode");
endmodule : pmcr_regs

// >>> test/pmcr_host.sv
// host model: drives the register port of the configuration bank
// assumes the bank answers a read in the cycle after the strobe
`timescale 1ns/100ps
module pmcr_host (
  input wire logic CLK,
  input wire logic [7:0] RDATA,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR,
  output logic RD
);
  // bus idles with strobes low
  initial begin
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end

  // one-cycle write; stale address and data are scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask : wr

  // one-cycle read; data sampled once the answering edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    ADDR <= ~a;
    #1;
    d = RDATA;
  endtask : rd

  task automatic wr_pair(input logic [7:0] pa, ca, v, m);
    wr(pa, v);
    wr(ca, ~v & m);
  endtask : wr_pair
endmodule : pmcr_host

// >>> test/proximity_measure_config_regs_tb.sv
// self-checking bench for the proximity configuration register bank
// assumes a shortened tick so measurement intervals stay a few cycles
`timescale 1ns/100ps
module proximity_measure_config_regs_tb;
  localparam int TICKS = 4;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [7:0] ADDR, WDATA, RDATA, rv;
  logic WR, RD, ACCUMULATE, LED_INVALID, MEAS_START;
  logic [8:0] PULSE_BURST;
  logic [1:0] GAIN_SEL;
  logic [3:0] SAMPLE_SHIFT;
  logic [7:0] cmp[3] = '{8'h95, 8'h96, 8'h97};
  logic [7:0] good[3] = '{8'h01, 8'h10, 8'h00};
  int err_total = 0;
  int tests_run = 0;
  int p1, p2;

  always #12.5 CLK = ~CLK;

  pmcr_host host (.CLK(CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
  pmcr_regs #(.TICK_CYC(TICKS)) dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PULSE_BURST(PULSE_BURST), .GAIN_SEL(GAIN_SEL),
    .SAMPLE_SHIFT(SAMPLE_SHIFT), .ACCUMULATE(ACCUMULATE), .LED_INVALID(LED_INVALID),
    .MEAS_START(MEAS_START));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk({1'b0, rv}, {1'b0, exp});
  endtask : rchk

  // registered outputs follow a write one edge later
  task automatic settle();
    @(posedge CLK);
    #1;
  endtask : settle

  // cycles until the next measurement pulse, bounded
  task automatic pulse_gap(output int n);
    n = 0;
    do begin
      settle();
      n++;
    end while (!MEAS_START && n < 300);
    if (n >= 300) begin
      err_total++;
      complete_run();
    end
  endtask : pulse_gap

  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    rchk(8'h84, 8'h00);
    rchk(8'h93, 8'h10);
    rchk(8'h94, 8'ha9);
    rchk(8'h95, 8'h01);
    rchk(8'h96, 8'h10);
    chk(PULSE_BURST, 9'h001);
    chk({5'h00, SAMPLE_SHIFT}, 9'h004);
    chk({8'h00, ACCUMULATE}, 9'h000);
    $display("test reset done");
    host.wr_pair(8'h82, 8'h95, 8'h0e, 8'h0f);
    host.wr_pair(8'h83, 8'h96, 8'h0f, 8'h1f);
    // both ends of the burst range
    for (int v = 0; v < 256; v += 255) begin
      host.wr_pair(8'h84, 8'h97, 8'(v), 8'hff);
      settle();
      chk(PULSE_BURST, 9'(v + 1));
      chk({8'h00, LED_INVALID}, 9'h000);
    end
    // each complement broken then mended in turn
    for (int i = 0; i < 3; i++) begin
      host.wr(cmp[i], good[i] ^ 8'h01);
      settle();
      chk({8'h00, LED_INVALID}, 9'h001);
      rchk(8'h99, 8'h08);
      host.wr(cmp[i], good[i]);
      settle();
      chk({8'h00, LED_INVALID}, 9'h000);
    end
    host.wr(8'h95, 8'hf1);
    rchk(8'h95, 8'h01);
    $display("test pairing done");
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h93, 8'h10 | 8'(c));
      settle();
      chk({7'h00, GAIN_SEL}, 9'(c));
    end
    // bit 6 rides on c[2]
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h94, 8'h89 | 8'(c << 4));
      settle();
      chk({5'h00, SAMPLE_SHIFT}, 9'(1 << (c % 4)));
      chk({8'h00, ACCUMULATE}, 9'(c / 4));
    end
    $display("test fields done");
    // one tick against four ticks; only the difference is fixed
    host.wr(8'h94, 8'ha3);
    host.wr(8'h81, 8'h02);
    pulse_gap(p1);
    pulse_gap(p1);
    host.wr(8'h94, 8'ha5);
    pulse_gap(p2);
    pulse_gap(p2);
    chk(9'(p2 - p1), 9'(3 * TICKS));
    host.wr(8'h81, 8'h00);
    // measurements left the new-data bit set; a read clears it
    rchk(8'h99, 8'h01);
    rchk(8'h99, 8'h00);
    rv = 8'h00;
    repeat (2) @(posedge CLK);
    repeat (40) begin
      settle();
      rv[0] = rv[0] | MEAS_START;
    end
    chk({1'b0, rv}, 9'h000);
    $display("test pacing done");
    host.wr(8'h84, 8'h55);
    host.wr(8'h81, 8'h01);
    rchk(8'h84, 8'h00);
    rchk(8'h94, 8'ha9);
    rchk(8'h00, 8'h00);
    $display("test soft reset done");
    complete_run();
  end
endmodule : proximity_measure_config_regs_tb
